/* File: rtl/dci_ctrl.v */
// Daisy-chain interrupt controller for a two-channel serial controller.
// Assumes channel event inputs come from logic on the same clock, chain,
// acknowledge, read and modem pins come from outside and are synchronised.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "dci_defs.vh"

module dci_ctrl (
  input wire clock,
  input wire resetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Daisy chain and acknowledge pins.
  input wire chainEnableIn,
  output reg chainEnableOut,
  input wire ackStrobeN,
  input wire readStrobeN,
  output reg irqOutN,
  output reg irqOe,
  output reg [7:0] dataOut,
  output reg dataOe,
  // Channel events, bit 0 is channel A, bit 1 channel B.
  input wire [1:0] rxCharPulse,
  input wire [1:0] rxFifoGe4,
  input wire [1:0] rxOverrun,
  input wire [1:0] rxFrameErr,
  input wire [1:0] rxEndFrame,
  input wire [1:0] rxParityErr,
  input wire [1:0] txTopEmpty,
  input wire [1:0] txAllEmpty,
  input wire [1:0] txUnderrun,
  input wire [1:0] brgZero,
  input wire [1:0] breakAbortLevel,
  // Modem pins, asynchronous to the clock.
  input wire [1:0] ctsPin,
  input wire [1:0] carrierDetectPin,
  input wire [1:0] syncPin
);

  // Software registers.
  reg [11:0] ctrl_q; // Write-only enables, six bits per channel.
  reg [15:0] ext_q; // Extension control, eight bits per channel.
  reg [7:0] vec_q; // Interrupt vector base.
  reg [7:0] master_q; // Master enable and vector status enable.
  // Interrupt state.
  reg [5:0] pend_q; // Pending bits, index 0 is highest priority.
  reg [5:0] pend_d;
  reg [5:0] ius_q; // In-service bits.
  reg [5:0] ius_d;
  reg [1:0] spec_q; // Receive pending came from a special condition.
  reg [1:0] spec_d;
  reg [1:0] first_q; // First character already reported.
  reg [1:0] first_d;
  // Synchronisers: stage one is read only by stage two.
  reg [8:0] pinMeta_q;
  reg [8:0] pinSync_q;
  reg [5:0] modemPrev_q; // Last synchronised modem levels.
  reg [1:0] brkPrev_q;
  reg [1:0] ge4Prev_q;
  reg ackPrev_q;
  // Acknowledge bookkeeping.
  reg ackOwn_q; // This device won the current acknowledge.
  reg [7:0] ackVec_q; // Vector latched at acknowledge.

  wire apbWrite = psel & penable & pready & pwrite;
  wire [5:0] cmdBits = pwdata[5:0];
  wire cmdHit = apbWrite & (paddr == `DCI_OFS_CMD);
  wire softAck = cmdHit & cmdBits[`DCI_CMD_SOFT_ACK];
  wire endSvc = cmdHit & cmdBits[`DCI_CMD_EOS];
  wire [1:0] rearm = cmdHit ? pwdata[`DCI_CMD_REARM_LO +: 2] : 2'h0;
  wire [5:0] clrPend = cmdHit ? pwdata[`DCI_CMD_CLR_LO +: 6] : 6'h00;

  wire chainIn = pinSync_q[0];
  wire ackNow = ~pinSync_q[1];
  wire rdLow = ~pinSync_q[2];
  wire [1:0] cts = pinSync_q[4:3];
  wire [1:0] dcd = pinSync_q[6:5];
  wire [1:0] syn = pinSync_q[8:7];
  wire master_enable = master_q[`DCI_MST_MIE];

  // Two flip-flops on every pin before any logic looks at it.
  always @(posedge clock) begin
    if (!resetn) begin
      // Stages start at the idle pin levels, so no false strobe or read
      // appears in the two cycles after reset while they refill.
      pinMeta_q <= `DCI_RST_PINS;
      pinSync_q <= `DCI_RST_PINS;
    end else begin
      pinMeta_q <= {syncPin, carrierDetectPin, ctsPin, readStrobeN, ackStrobeN, chainEnableIn};
      pinSync_q <= pinMeta_q;
    end
  end

  // Per channel: enables and the set event of each of its three sources.
  wire [5:0] srcEn;
  wire [5:0] srcSet;
  wire [1:0] specEv;
  wire [1:0] charEv;
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : gCh
      wire [5:0] ctl = ctrl_q[6*c +: 6];
      wire [7:0] ext = ext_q[8*c +: 8];
      wire [1:0] mode = ctl[`DCI_CTL_RXMODE_LO +: 2];
      // Receive character: every pulse, or arrival at four bytes.
      wire chr = ext[`DCI_EXT_RX4] ? (rxFifoGe4[c] & ~ge4Prev_q[c]) : rxCharPulse[c];
      wire spc = rxOverrun[c] | rxFrameErr[c] | rxEndFrame[c] |
        (ctl[`DCI_CTL_PAR_SPEC] & rxParityErr[c]);
      wire chrOk = (mode == `DCI_RX_ALL) | ((mode == `DCI_RX_FIRST) & ~first_q[c]);
      wire txEv = ext[`DCI_EXT_TXALL] ? txAllEmpty[c] : txTopEmpty[c];
      // Modem edges in either direction and line events.
      wire pinEdge = (cts[c] ^ modemPrev_q[c]) | (dcd[c] ^ modemPrev_q[2 + c]) |
        (syn[c] ^ modemPrev_q[4 + c]);
      wire brkEdge = breakAbortLevel[c] ^ brkPrev_q[c];
      wire extEv = pinEdge | txUnderrun[c] | brgZero[c] | brkEdge;
      assign srcEn[3*c] = (mode != `DCI_RX_OFF);
      assign srcEn[3*c + 1] = ctl[`DCI_CTL_TX_EN];
      assign srcEn[3*c + 2] = ctl[`DCI_CTL_EXT_EN];
      assign charEv[c] = chr & chrOk;
      // Specials are taken in every enabled mode, also after the first character.
      assign specEv[c] = spc;
      assign srcSet[3*c] = charEv[c] | specEv[c];
      assign srcSet[3*c + 1] = txEv;
      assign srcSet[3*c + 2] = extEv;
    end
  endgenerate

  // Edge history for modem pins, break level and the four-byte threshold.
  always @(posedge clock) begin
    if (!resetn) begin
      modemPrev_q <= 6'h00;
      brkPrev_q <= 2'h0;
      ge4Prev_q <= 2'h0;
      ackPrev_q <= 1'b0;
    end else begin
      modemPrev_q <= {syn, dcd, cts};
      brkPrev_q <= breakAbortLevel;
      ge4Prev_q <= rxFifoGe4;
      ackPrev_q <= ackNow;
    end
  end

  // Internal chain: a source is eligible only if nothing at or above it is
  // in service. Lower index is higher priority, channel A first.
  reg [5:0] elig;
  reg [5:0] topOne;
  reg blk;
  // Each combinational process owns its loop index, so that no variable
  // is driven from two processes.
  integer i; // Loop index of the chain process.
  integer j; // Loop index of the in-service scan.
  integer k; // Loop index of the next-state process.
  always @* begin
    blk = 1'b0;
    elig = 6'h00;
    topOne = 6'h00;
    for (i = 0; i < 6; i = i + 1) begin
      blk = blk | ius_q[i];
      elig[i] = pend_q[i] & ~blk;
    end
    blk = 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      topOne[i] = elig[i] & ~blk;
      blk = blk | elig[i];
    end
  end

  // Request exists only with master enable and a free chain above us.
  wire reqAny = master_enable & chainIn & (|elig);

  // Status code of the highest eligible source; special receive differs
  // from an ordinary character only here.
  reg [2:0] statCode;
  always @* begin
    statCode = `DCI_CODE_NONE;
    if (topOne[0]) begin
      statCode = spec_q[0] ? `DCI_CODE_A_SPEC : 3'h6;
    end else if (topOne[1]) begin
      statCode = 3'h4;
    end else if (topOne[2]) begin
      statCode = 3'h5;
    end else if (topOne[3]) begin
      statCode = spec_q[1] ? `DCI_CODE_B_SPEC : 3'h2;
    end else if (topOne[4]) begin
      statCode = 3'h0;
    end else if (topOne[5]) begin
      statCode = 3'h1;
    end
  end

  // Vector with three bits replaced by status.
  wire [7:0] vecStat = {vec_q[7:4], statCode, vec_q[0]};
  wire [7:0] vecAck = master_q[`DCI_MST_VIS] ? vecStat : vec_q;
  // A hardware acknowledge starts on the falling strobe; software may do the same.
  wire ackGo = (ackNow & ~ackPrev_q) | softAck;
  wire ackWin = ackGo & reqAny;

  // Lowest set in-service bit is the one being serviced now.
  reg [5:0] iusTop;
  reg seen;
  always @* begin
    seen = 1'b0;
    iusTop = 6'h00;
    for (j = 0; j < 6; j = j + 1) begin
      iusTop[j] = ius_q[j] & ~seen;
      seen = seen | ius_q[j];
    end
  end

  // Next state of pending, in-service and receive flags.
  always @* begin
    // Set beats clear; disabled sources never set.
    pend_d = (pend_q & ~clrPend) | (srcSet & srcEn);
    spec_d = spec_q;
    first_d = first_q & ~rearm;
    for (k = 0; k < 2; k = k + 1) begin
      // The special flag follows the receive pending bit; a new special
      // in the same cycle as a clear keeps it set.
      if (clrPend[3*k]) begin
        spec_d[k] = 1'b0;
      end
      if (specEv[k] & srcEn[3*k]) begin
        spec_d[k] = 1'b1;
      end
      // A reported character closes first-character mode until re-armed.
      if (charEv[k] & srcEn[3*k]) begin
        first_d[k] = 1'b1;
      end
    end
    ius_d = ius_q;
    if (endSvc) begin
      ius_d = ius_q & ~iusTop;
    end
    if (ackWin) begin
      ius_d = ius_d | topOne;
    end
  end

  // Interrupt state registers.
  always @(posedge clock) begin
    if (!resetn) begin
      pend_q <= 6'h00;
      ius_q <= 6'h00;
      spec_q <= 2'h0;
      first_q <= 2'h0;
    end else begin
      pend_q <= pend_d;
      ius_q <= ius_d;
      spec_q <= spec_d;
      first_q <= first_d;
    end
  end

  // Pin side: request, chain out and vector drive.
  always @(posedge clock) begin
    if (!resetn) begin
      irqOutN <= 1'b0;
      irqOe <= 1'b0;
      chainEnableOut <= 1'b0;
      ackOwn_q <= 1'b0;
      ackVec_q <= 8'h00;
      dataOut <= 8'h00;
      dataOe <= 1'b0;
    end else begin
      irqOutN <= 1'b0; // Open drain: only the enable toggles.
      // Released for the whole acknowledge cycle.
      irqOe <= reqAny & ~ackNow;
      chainEnableOut <= chainIn & ~(|ius_q) & ~(ackNow & reqAny);
      if (ackWin) begin
        ackOwn_q <= ~softAck | ackNow;
        ackVec_q <= vecAck;
      end else if (!ackNow) begin
        ackOwn_q <= 1'b0;
      end
      dataOut <= ackVec_q;
      dataOe <= ackOwn_q & ackNow & chainIn & rdLow;
    end
  end

  // Read multiplexer; the enable register reads as zero.
  reg [31:0] rdata;
  reg rerr;
  always @* begin
    rerr = 1'b0;
    case (paddr)
      `DCI_OFS_CTRL_A: rdata = 32'h0000_0000;
      `DCI_OFS_CTRL_B: rdata = 32'h0000_0000;
      `DCI_OFS_EXT_A: rdata = {24'h00_0000, ext_q[7:0]};
      `DCI_OFS_EXT_B: rdata = {24'h00_0000, ext_q[15:8]};
      `DCI_OFS_VEC_WR: rdata = {24'h00_0000, vec_q};
      `DCI_OFS_VEC_RD_A: rdata = {24'h00_0000, vec_q};
      `DCI_OFS_VEC_RD_B: rdata = {24'h00_0000, vecStat};
      `DCI_OFS_PEND: rdata = {26'h000_0000, pend_q};
      `DCI_OFS_MASTER: rdata = {24'h00_0000, master_q};
      `DCI_OFS_CMD: rdata = 32'h0000_0000;
      `DCI_OFS_IUS: rdata = {26'h000_0000, ius_q};
      default: begin
        rdata = 32'h0000_0000;
        rerr = 1'b1;
      end
    endcase
  end

  // APB slave: the answer is registered in the setup cycle, so every access
  // phase completes in one cycle with no wait state.
  always @(posedge clock) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata;
      pready <= 1'b1;
      pslverr <= rerr;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Register writes take effect at the completing edge.
  always @(posedge clock) begin
    if (!resetn) begin
      ctrl_q <= `DCI_RST_CTRL;
      ext_q <= `DCI_RST_EXT;
      vec_q <= `DCI_RST_VEC;
      master_q <= `DCI_RST_MASTER;
    end else if (apbWrite) begin
      case (paddr)
        `DCI_OFS_CTRL_A: ctrl_q[5:0] <= pwdata[5:0];
        `DCI_OFS_CTRL_B: ctrl_q[11:6] <= pwdata[5:0];
        `DCI_OFS_EXT_A: ext_q[7:0] <= pwdata[7:0];
        `DCI_OFS_EXT_B: ext_q[15:8] <= pwdata[7:0];
        `DCI_OFS_VEC_WR: vec_q <= pwdata[7:0];
        `DCI_OFS_MASTER: master_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

endmodule

/* File: rtl/dci_defs.vh */
// Constants of the daisy-chain interrupt controller: register offsets,
// field positions, reset values and vector coding.
// Assumes inclusion by bare name from the design file.
`ifndef DCI_DEFS_VH
`define DCI_DEFS_VH
// APB byte addresses of the registers.
`define DCI_OFS_CTRL_A 8'h00
`define DCI_OFS_CTRL_B 8'h04
`define DCI_OFS_EXT_A 8'h08
`define DCI_OFS_EXT_B 8'h0C
`define DCI_OFS_VEC_WR 8'h10
`define DCI_OFS_VEC_RD_A 8'h14
`define DCI_OFS_VEC_RD_B 8'h18
`define DCI_OFS_PEND 8'h1C
`define DCI_OFS_MASTER 8'h20
`define DCI_OFS_CMD 8'h24
`define DCI_OFS_IUS 8'h28
// Fields of the per-channel irq control register.
`define DCI_CTL_EXT_EN 0
`define DCI_CTL_TX_EN 1
`define DCI_CTL_RXMODE_LO 2
`define DCI_CTL_PAR_SPEC 4
// Receive interrupt modes.
`define DCI_RX_OFF 2'h0
`define DCI_RX_FIRST 2'h1
`define DCI_RX_ALL 2'h2
`define DCI_RX_SPEC 2'h3
// Fields of the per-channel extension control register.
`define DCI_EXT_RX4 3
`define DCI_EXT_TXALL 5
// Fields of the master control register.
`define DCI_MST_VIS 0
`define DCI_MST_MIE 3
// Fields of the command register.
`define DCI_CMD_SOFT_ACK 0
`define DCI_CMD_EOS 1
`define DCI_CMD_REARM_LO 2
`define DCI_CMD_CLR_LO 8
// Reset values.
`define DCI_RST_CTRL 12'h000
`define DCI_RST_EXT 16'h0000
`define DCI_RST_VEC 8'h00
`define DCI_RST_MASTER 8'h00
// Idle levels of the pin synchronisers: chain in, acknowledge and read high.
`define DCI_RST_PINS 9'h007
// Vector status field position and codes.
`define DCI_VEC_STAT_LO 1
`define DCI_CODE_NONE 3'h3
`define DCI_CODE_A_SPEC 3'h7
`define DCI_CODE_B_SPEC 3'h3
`endif

/* File: tb/dci_ctrl_sva.sv */
// Port checker for the interrupt controller.
// Assumes it is bound into dci_ctrl and sees only its ports.
`timescale 1ns/10ps
module dci_ctrl_sva (
  input wire clock,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire chainEnableIn,
  input wire chainEnableOut,
  input wire ackStrobeN,
  input wire readStrobeN,
  input wire irqOutN,
  input wire irqOe,
  input wire dataOe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Shadows of the vector and master enable, taken at the APB write edge.
  reg [7:0] vec_q;
  reg mie_q;
  always @(posedge clock) begin
    if (!resetn) begin
      vec_q <= 8'h00;
      mie_q <= 1'b0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == 8'h10) vec_q <= pwdata[7:0];
      if (paddr == 8'h20) mie_q <= pwdata[3];
    end
  end
  // The request pin is open drain, so only its enable may move.
  property p_pin_low; irqOutN == 1'b0; endproperty
  a_pin_low: assert property (p_pin_low) else $error("request level wrong");
  property p_mie_off; !mie_q [*3] |-> !irqOe; endproperty
  a_mie_off: assert property (p_mie_off) else $error("request without master enable");
  property p_ack_release; !ackStrobeN [*5] |-> !irqOe; endproperty
  a_ack_release: assert property (p_ack_release) else $error("request held in acknowledge");
  property p_chain_out; !chainEnableIn [*5] |-> !chainEnableOut; endproperty
  a_chain_out: assert property (p_chain_out) else $error("chain out without chain in");
  property p_read_gate; readStrobeN [*6] |-> !dataOe; endproperty
  a_read_gate: assert property (p_read_gate) else $error("vector driven without read");
  property p_ctrl_wo; psel && pready && !pwrite && (paddr == 8'h00 || paddr == 8'h04) |-> prdata == 32'h0000_0000;
  endproperty
  a_ctrl_wo: assert property (p_ctrl_wo) else $error("enable bits readable");
  property p_vec_a; psel && pready && !pwrite && paddr == 8'h14 |-> prdata[7:0] == vec_q; endproperty
  a_vec_a: assert property (p_vec_a) else $error("plain vector wrong");
  property p_vec_b; psel && pready && !pwrite && paddr == 8'h18 |-> {prdata[7:4], prdata[0]} == {vec_q[7:4], vec_q[0]};
  endproperty
  a_vec_b: assert property (p_vec_b) else $error("status vector fixed bits wrong");
endmodule
bind dci_ctrl dci_ctrl_sva u_sva (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .chainEnableIn(chainEnableIn), .chainEnableOut(chainEnableOut), .ackStrobeN(ackStrobeN),
  .readStrobeN(readStrobeN), .irqOutN(irqOutN), .irqOe(irqOe), .dataOe(dataOe));

/* File: tb/dci_host_model.sv */
// Host model that runs one hardware acknowledge cycle on request.
// Assumes start is a one-cycle pulse on the controller clock.
`timescale 1ns/10ps
module dci_host_model (
  input wire clock,
  input wire resetn,
  input wire start,
  output wire ackStrobeN,
  output wire readStrobeN
);
  // Step within the acknowledge cycle, zero while idle.
  reg [3:0] step_q;
  always @(posedge clock) begin
    if (!resetn) begin
      step_q <= 4'h0;
    end else if (start || step_q != 4'h0) begin
      step_q <= step_q + 4'h1;
    end
  end
  // Read sits inside the strobe so the chain has settled before the bus turns.
  assign ackStrobeN = (step_q == 4'h0);
  assign readStrobeN = !(step_q >= 4'h4 && step_q <= 4'hC);
endmodule

/* File: tb/dci_ctrl_test.sv */
// Directed testbench of the interrupt controller over APB and its pins.
// Assumes dci_ctrl, the host model and the bound checker are compiled.
`timescale 1ns/10ps
module dci_ctrl_test;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, chainEnableIn = 1'b1, ackGo = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [27:0] ev = 28'h000_0000;
  wire [31:0] prdata;
  wire [7:0] dataOut;
  wire pready, pslverr, chainEnableOut, irqOutN, irqOe, dataOe, ackStrobeN, readStrobeN;
  logic [31:0] rd;
  logic errQ;
  int err_total = 0, n_tests = 0, i;
  int spec[4] = '{4, 6, 8, 10};
  int extK[8] = '{16, 18, 20, 20, 22, 24, 26, 22};
  always #4 clock = ~clock;
  dci_ctrl u_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chainEnableIn(chainEnableIn),
    .chainEnableOut(chainEnableOut), .ackStrobeN(ackStrobeN), .readStrobeN(readStrobeN), .irqOutN(irqOutN),
    .irqOe(irqOe), .dataOut(dataOut), .dataOe(dataOe), .rxCharPulse(ev[1:0]), .rxFifoGe4(ev[3:2]),
    .rxOverrun(ev[5:4]), .rxFrameErr(ev[7:6]), .rxEndFrame(ev[9:8]), .rxParityErr(ev[11:10]),
    .txTopEmpty(ev[13:12]), .txAllEmpty(ev[15:14]), .txUnderrun(ev[17:16]), .brgZero(ev[19:18]),
    .breakAbortLevel(ev[21:20]), .ctsPin(ev[23:22]), .carrierDetectPin(ev[25:24]), .syncPin(ev[27:26]));
  dci_host_model u_host (.clock(clock), .resetn(resetn), .start(ackGo), .ackStrobeN(ackStrobeN),
    .readStrobeN(readStrobeN));
  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    errQ = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      check("pready", 1, 0);
      report_and_stop;
    end
    @(posedge clock);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string w);
    apb(1'b0, a, 32'h0000_0000);
    check(w, e, rd);
  endtask
  // Pulse an event for one cycle, or toggle a level, then let pin sync settle.
  task automatic fire(input int k, input bit lvl);
    ev[k] <= ~ev[k];
    @(posedge clock);
    if (!lvl) ev[k] <= 1'b0;
    repeat (5) @(posedge clock);
  endtask
  task automatic waitIrq(input logic v);
    for (i = 0; i < 20 && irqOe !== v; i++) @(posedge clock);
    check("irqOe", v, irqOe);
    if (irqOe !== v) report_and_stop;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    apb(1'b1, 8'h00, 32'h0000_001F);
    rdc(8'h00, 32'h0000_0000, "ctrlA");
    apb(1'b1, 8'h10, 32'h0000_00A5);
    rdc(8'h14, 32'h0000_00A5, "vecA");
    apb(1'b1, 8'h20, 32'h0000_0009);
    apb(1'b1, 8'h00, 32'h0000_0008);
    apb(1'b1, 8'h04, 32'h0000_0002);
    fire(13, 1'b0);
    fire(0, 1'b0);
    rdc(8'h1C, 32'h0000_0011, "pend");
    waitIrq(1'b1);
    rdc(8'h18, 32'h0000_00AD, "vecB");
    chainEnableIn <= 1'b0;
    waitIrq(1'b0);
    apb(1'b1, 8'h24, 32'h0000_0001);
    rdc(8'h28, 32'h0000_0000, "iusBlocked");
    check("chainOff", 0, chainEnableOut);
    chainEnableIn <= 1'b1;
    waitIrq(1'b1);
    check("irqLevel", 0, irqOutN);
    ackGo <= 1'b1;
    @(posedge clock);
    ackGo <= 1'b0;
    for (i = 0; i < 20 && dataOe !== 1'b1; i++) @(posedge clock);
    check("dataOe", 1, dataOe);
    if (dataOe !== 1'b1) report_and_stop;
    check("ackVec", 32'h0000_00AD, {24'h00_0000, dataOut});
    check("irqAck", 0, irqOe);
    for (i = 0; i < 20 && ackStrobeN !== 1'b1; i++) @(posedge clock);
    if (ackStrobeN !== 1'b1) begin
      check("ackEnd", 1, ackStrobeN);
      report_and_stop;
    end
    rdc(8'h28, 32'h0000_0001, "ius");
    check("chainOut", 0, chainEnableOut);
    apb(1'b1, 8'h24, 32'h0000_0102);
    rdc(8'h28, 32'h0000_0000, "iusEnd");
    check("chainFree", 1, chainEnableOut);
    waitIrq(1'b1);
    apb(1'b1, 8'h24, 32'h0000_0001);
    rdc(8'h28, 32'h0000_0010, "softAck");
    apb(1'b1, 8'h24, 32'h0000_3F02);
    rdc(8'h1C, 32'h0000_0000, "pendClr");
    apb(1'b1, 8'h20, 32'h0000_0001);
    fire(1, 1'b0);
    fire(13, 1'b0);
    rdc(8'h1C, 32'h0000_0010, "pendOff");
    check("irqMie", 0, irqOe);
    apb(1'b1, 8'h24, 32'h0000_3F00);
    apb(1'b1, 8'h20, 32'h0000_0009);
    apb(1'b1, 8'h00, 32'h0000_001C);
    fire(0, 1'b0);
    rdc(8'h1C, 32'h0000_0000, "specOnly");
    foreach (spec[j]) begin
      fire(spec[j], 1'b0);
      rdc(8'h1C, 32'h0000_0001, "special");
      rdc(8'h18, 32'h0000_00AF, "vecSpec");
      apb(1'b1, 8'h24, 32'h0000_0100);
    end
    apb(1'b1, 8'h00, 32'h0000_0001);
    foreach (extK[j]) begin
      fire(extK[j], extK[j] >= 20);
      rdc(8'h1C, 32'h0000_0004, "extStat");
      apb(1'b1, 8'h24, 32'h0000_0400);
    end
    apb(1'b1, 8'h08, 32'h0000_0020);
    apb(1'b1, 8'h00, 32'h0000_0002);
    fire(12, 1'b0);
    rdc(8'h1C, 32'h0000_0000, "txTop");
    fire(14, 1'b0);
    rdc(8'h1C, 32'h0000_0002, "txAll");
    apb(1'b1, 8'h24, 32'h0000_0200);
    apb(1'b1, 8'h08, 32'h0000_0008);
    apb(1'b1, 8'h00, 32'h0000_0008);
    fire(0, 1'b0);
    rdc(8'h1C, 32'h0000_0000, "rxWait");
    fire(2, 1'b1);
    rdc(8'h1C, 32'h0000_0001, "rxFour");
    apb(1'b1, 8'h08, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0004);
    apb(1'b1, 8'h24, 32'h0000_0104);
    fire(0, 1'b0);
    rdc(8'h1C, 32'h0000_0001, "rxFirst");
    apb(1'b1, 8'h24, 32'h0000_0100);
    fire(0, 1'b0);
    rdc(8'h1C, 32'h0000_0000, "rxFirstOnce");
    fire(4, 1'b0);
    rdc(8'h1C, 32'h0000_0001, "rxFirstSpec");
    apb(1'b1, 8'h24, 32'h0000_0104);
    fire(0, 1'b0);
    rdc(8'h1C, 32'h0000_0001, "rxRearm");
    apb(1'b0, 8'h3C, 32'h0000_0000);
    check("slvErr", 1, errQ);
    report_and_stop;
  end
endmodule
